// >>> hw/shared_sfr_regs.svh
// Offsets, bit positions, reset values and mode codes of the shared register decode
`ifndef SHARED_SFR_REGS_SVH
`define SHARED_SFR_REGS_SVH

// Shared addresses: default register when select is 0, alternate when 1
`define ADDR_OSC_REFCLK 12'hfd3
`define ADDR_T1H_OD1 12'hfcf
`define ADDR_T1L_OD2 12'hfce
`define ADDR_TIMER1_CTRL_OD3 12'hfcd
`define ADDR_T2_PAD 12'hfcc
`define ADDR_PR2_MEMCFG 12'hfcb
`define ADDR_ADC0_AN1 12'hfc2
`define ADDR_ADC1_AN0 12'hfc1
`define ADDR_PR4_VREF 12'hf77

// Watchdog and alias control register
`define ADDR_WDT_CTRL 12'hfc0

// Context-defined aliases
`define ADDR_SERIAL_ADDR 12'hfc8
`define ADDR_PARPORT_HIGH 12'hf69
`define ADDR_PARPORT_LOW 12'hf68

// Watchdog control field positions
`define WDT_LOWPOWER_BIT 7
`define WDT_SUPPLY_OK_BIT 6
`define WDT_SELECT_BIT 4
`define WDT_SOFT_WDT_BIT 0

// Slot count and the slot whose alternate exists on the large package only
`define SHARED_SLOTS 9
`define SLOT_NONE 4'hf
`define SLOT_MEMORY_CFG 4'h5

// Serial control 2 low nibble that exposes the address mask
`define SERIAL_MASK_MODE 4'h9

// Reset values
`define RESET_BYTE 8'h00
`define RESET_PAIR 16'h0000

`endif

// >>> hw/shared_sfr_pkg.sv
// Types shared by the shared register address decode
package shared_sfr_pkg;

  // One core register access, as presented in one cycle
  typedef struct packed {
    logic [11:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_t;

  // Context inputs coming from the peripherals that own the aliases
  typedef struct packed {
    logic [3:0] serial_ctrl2_low;
    logic parport_master;
    logic variant_80pin;
    logic core_supply_ok;
  } context_t;

endpackage

// >>> hw/shared_sfr_address_decode.sv
// Shared and context-defined special register address decode with the watchdog control byte
`timescale 1ns/1ps
`default_nettype none
`include "shared_sfr_regs.svh"

module shared_sfr_address_decode (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Core register access
  input wire shared_sfr_pkg::reg_req_t req_i,
  // Peripheral context
  input wire shared_sfr_pkg::context_t ctx_i,
  // Read data, valid the cycle after a read strobe
  output logic [7:0] rdata_o,
  // Watchdog control outputs
  output logic alias_select_o,
  output logic soft_watchdog_en_o,
  output logic regulator_lowpower_en_o,
  // Context-alias storage toward the peripherals
  output logic [7:0] serial_slave_addr_o,
  output logic [7:0] serial_addr_mask_o,
  output logic [15:0] parport_pair_o
);

  // Map a shared address to its slot, or none
  function automatic logic [3:0] shared_slot(input logic [11:0] a);
    case (a)
      `ADDR_OSC_REFCLK: shared_slot = 4'h0;
      `ADDR_T1H_OD1: shared_slot = 4'h1;
      `ADDR_T1L_OD2: shared_slot = 4'h2;
      `ADDR_TIMER1_CTRL_OD3: shared_slot = 4'h3;
      `ADDR_T2_PAD: shared_slot = 4'h4;
      `ADDR_PR2_MEMCFG: shared_slot = 4'h5;
      `ADDR_ADC0_AN1: shared_slot = 4'h6;
      `ADDR_ADC1_AN0: shared_slot = 4'h7;
      `ADDR_PR4_VREF: shared_slot = 4'h8;
      default: shared_slot = `SLOT_NONE;
    endcase
  endfunction

  // Default (legacy) and alternate storage, one byte per slot
  logic [7:0] dflt_q [`SHARED_SLOTS];
  logic [7:0] alt_q [`SHARED_SLOTS];
  logic [7:0] next_dflt [`SHARED_SLOTS];
  logic [7:0] next_alt [`SHARED_SLOTS];
  // Watchdog control bits
  logic alias_select;
  logic soft_watchdog_en;
  logic regulator_lowpower_en;
  logic next_alias_select;
  logic next_soft_watchdog_en;
  logic next_regulator_lowpower_en;
  // Context-alias storage
  logic [7:0] serial_slave_addr;
  logic [7:0] serial_addr_mask;
  logic [15:0] parport_pair;
  logic [7:0] next_serial_slave_addr;
  logic [7:0] next_serial_addr_mask;
  logic [15:0] next_parport_pair;
  logic [7:0] next_rdata;
  // Decode helpers
  logic [3:0] slot;
  logic mask_mode;
  logic alt_present;

  assign slot = shared_slot(req_i.addr);
  // Mode comes from the serial port, not from the alias select
  assign mask_mode = (ctx_i.serial_ctrl2_low == `SERIAL_MASK_MODE);
  // Memory config alternate is absent on the small package
  assign alt_present = (slot != `SLOT_MEMORY_CFG) || ctx_i.variant_80pin;

  // Next-state for every register, and the read mux
  always_comb
  begin
    next_dflt = dflt_q;
    next_alt = alt_q;
    next_alias_select = alias_select;
    next_soft_watchdog_en = soft_watchdog_en;
    next_regulator_lowpower_en = regulator_lowpower_en;
    next_serial_slave_addr = serial_slave_addr;
    next_serial_addr_mask = serial_addr_mask;
    next_parport_pair = parport_pair;
    next_rdata = `RESET_BYTE;
    // Writes: only the selected partner of a pair changes
    if (req_i.wr)
    begin
      if (slot != `SLOT_NONE)
      begin
        if (!alias_select)
        begin
          next_dflt[slot] = req_i.wdata;
        end
        else if (alt_present)
        begin
          next_alt[slot] = req_i.wdata;
        end
      end
      else
      begin
        case (req_i.addr)
          `ADDR_WDT_CTRL:
          begin
            // Unimplemented bits and the status bit are simply not stored
            next_regulator_lowpower_en = req_i.wdata[`WDT_LOWPOWER_BIT];
            next_alias_select = req_i.wdata[`WDT_SELECT_BIT];
            next_soft_watchdog_en = req_i.wdata[`WDT_SOFT_WDT_BIT];
          end
          `ADDR_SERIAL_ADDR:
          begin
            if (mask_mode)
            begin
              next_serial_addr_mask = req_i.wdata;
            end
            else
            begin
              next_serial_slave_addr = req_i.wdata;
            end
          end
          // One storage whatever the parallel port mode
          `ADDR_PARPORT_HIGH: next_parport_pair[15:8] = req_i.wdata;
          `ADDR_PARPORT_LOW: next_parport_pair[7:0] = req_i.wdata;
          default: next_rdata = `RESET_BYTE;
        endcase
      end
    end
    // Reads: unmapped addresses and absent slots read zero
    if (req_i.rd)
    begin
      if (slot != `SLOT_NONE)
      begin
        if (!alias_select)
        begin
          next_rdata = dflt_q[slot];
        end
        else if (alt_present)
        begin
          next_rdata = alt_q[slot];
        end
      end
      else
      begin
        case (req_i.addr)
          `ADDR_WDT_CTRL:
          begin
            next_rdata[`WDT_LOWPOWER_BIT] = regulator_lowpower_en;
            next_rdata[`WDT_SUPPLY_OK_BIT] = ctx_i.core_supply_ok;
            next_rdata[`WDT_SELECT_BIT] = alias_select;
            next_rdata[`WDT_SOFT_WDT_BIT] = soft_watchdog_en;
          end
          `ADDR_SERIAL_ADDR: next_rdata = mask_mode ? serial_addr_mask : serial_slave_addr;
          `ADDR_PARPORT_HIGH: next_rdata = parport_pair[15:8];
          `ADDR_PARPORT_LOW: next_rdata = parport_pair[7:0];
          default: next_rdata = `RESET_BYTE;
        endcase
      end
    end
  end

  // Register everything; synchronous reset to constants only
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < `SHARED_SLOTS; i++)
      begin
        dflt_q[i] <= `RESET_BYTE;
        alt_q[i] <= `RESET_BYTE;
      end
      alias_select <= 1'b0;
      soft_watchdog_en <= 1'b0;
      regulator_lowpower_en <= 1'b0;
      serial_slave_addr <= `RESET_BYTE;
      serial_addr_mask <= `RESET_BYTE;
      parport_pair <= `RESET_PAIR;
      rdata_o <= `RESET_BYTE;
    end
    else
    begin
      dflt_q <= next_dflt;
      alt_q <= next_alt;
      alias_select <= next_alias_select;
      soft_watchdog_en <= next_soft_watchdog_en;
      regulator_lowpower_en <= next_regulator_lowpower_en;
      serial_slave_addr <= next_serial_slave_addr;
      serial_addr_mask <= next_serial_addr_mask;
      parport_pair <= next_parport_pair;
      rdata_o <= next_rdata;
    end
  end

  // Outputs straight from the flops above
  assign alias_select_o = alias_select;
  assign soft_watchdog_en_o = soft_watchdog_en;
  assign regulator_lowpower_en_o = regulator_lowpower_en;
  assign serial_slave_addr_o = serial_slave_addr;
  assign serial_addr_mask_o = serial_addr_mask;
  assign parport_pair_o = parport_pair;

  // Select clear: write lands in default, alternate untouched
  property p_default_write;
    @(posedge clock_i) disable iff (!rst_n_i)
    (req_i.wr && req_i.addr == `ADDR_OSC_REFCLK && !alias_select)
      |=> (dflt_q[0] == $past(req_i.wdata)) && $stable(alt_q[0]);
  endproperty
  a_default_write: assert property (p_default_write)
    else $error("default slot write misrouted");

  // Select set: write lands in alternate, default untouched
  property p_alternate_write;
    @(posedge clock_i) disable iff (!rst_n_i)
    (req_i.wr && req_i.addr == `ADDR_PR4_VREF && alias_select)
      |=> (alt_q[8] == $past(req_i.wdata)) && $stable(dflt_q[8]);
  endproperty
  a_alternate_write: assert property (p_alternate_write)
    else $error("alternate slot write misrouted");

  // Select bit follows bit 4 of a control write and holds otherwise
  property p_select_bit;
    @(posedge clock_i) disable iff (!rst_n_i)
    (req_i.wr && req_i.addr == `ADDR_WDT_CTRL) ##1 (!req_i.wr)[*2]
      |=> alias_select == $past(req_i.wdata[`WDT_SELECT_BIT], 3);
  endproperty
  a_select_bit: assert property (p_select_bit)
    else $error("alias select did not hold written value");

  // Reset clears all control bits
  property p_reset_clear;
    @(posedge clock_i) disable iff (1'b0)
    !rst_n_i |=> !alias_select_o && !soft_watchdog_en_o && !regulator_lowpower_en_o;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("control bits not cleared by reset");

  // Control read: unimplemented bits zero, status reflects supply
  property p_ctrl_read;
    @(posedge clock_i) disable iff (!rst_n_i)
    (req_i.rd && !req_i.wr && req_i.addr == `ADDR_WDT_CTRL)
      |=> rdata_o[5] == 1'b0 && rdata_o[3:1] == 3'h0 && rdata_o[6] == $past(ctx_i.core_supply_ok)
          && rdata_o[0] == soft_watchdog_en && rdata_o[7] == regulator_lowpower_en;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control register read wrong");

  // Small package: memory config alternate never changes and reads zero
  property p_memcfg_absent;
    @(posedge clock_i) disable iff (!rst_n_i)
    (!ctx_i.variant_80pin && alias_select && req_i.addr == `ADDR_PR2_MEMCFG && req_i.rd)
      |=> $stable(alt_q[5]) && rdata_o == 8'h00;
  endproperty
  a_memcfg_absent: assert property (p_memcfg_absent)
    else $error("absent memory config slot responded");

  // Serial alias read follows the control nibble, never the select bit
  property p_serial_read;
    @(posedge clock_i) disable iff (!rst_n_i)
    (req_i.rd && !req_i.wr && req_i.addr == `ADDR_SERIAL_ADDR)
      |=> rdata_o == (($past(ctx_i.serial_ctrl2_low) == `SERIAL_MASK_MODE) ? serial_addr_mask
                                                              : serial_slave_addr);
  endproperty
  a_serial_read: assert property (p_serial_read)
    else $error("serial alias read wrong register");

  // Serial write in mask mode leaves the slave address alone
  property p_serial_write;
    @(posedge clock_i) disable iff (!rst_n_i)
    (req_i.wr && req_i.addr == `ADDR_SERIAL_ADDR && ctx_i.serial_ctrl2_low == `SERIAL_MASK_MODE)
      |=> serial_addr_mask == $past(req_i.wdata) && $stable(serial_slave_addr);
  endproperty
  a_serial_write: assert property (p_serial_write)
    else $error("serial mask write misrouted");

  // Parallel pair stores the same byte in master and slave modes
  property p_parport_write;
    @(posedge clock_i) disable iff (!rst_n_i)
    (req_i.wr && req_i.addr == `ADDR_PARPORT_HIGH)
      |=> parport_pair_o[15:8] == $past(req_i.wdata) && $stable(parport_pair_o[7:0]);
  endproperty
  a_parport_write: assert property (p_parport_write)
    else $error("parallel pair write lost");

  // Slave mode read sees the very storage that master mode wrote
  property p_parport_mode;
    @(posedge clock_i) disable iff (!rst_n_i)
    (req_i.rd && !req_i.wr && req_i.addr == `ADDR_PARPORT_HIGH && !ctx_i.parport_master)
      |=> rdata_o == $past(parport_pair[15:8]);
  endproperty
  a_parport_mode: assert property (p_parport_mode)
    else $error("parallel pair read depends on mode");

endmodule

`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the shared register address decode
`timescale 1ns/1ps
`default_nettype none
`include "shared_sfr_regs.svh"

`define CHK(nm, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("unexpected %s expected %h seen %h", nm, exp, got); \
    end \
  end

module testbench;
  // Design ports
  logic clock_i;
  logic rst_n_i;
  shared_sfr_pkg::reg_req_t req_i;
  shared_sfr_pkg::context_t ctx_i;
  logic [7:0] rdata_o;
  logic alias_select_o;
  logic soft_watchdog_en_o;
  logic regulator_lowpower_en_o;
  logic [7:0] serial_slave_addr_o;
  logic [7:0] serial_addr_mask_o;
  logic [15:0] parport_pair_o;
  // Score keeping
  int err_total;
  int n_checks;
  int cycles;
  // Read strobe seen last edge, so rdata_o is due now
  logic rd_d;
  logic [7:0] exp_q[$];
  logic [7:0] e;
  // Context applied with the next request, keeping the two aligned
  shared_sfr_pkg::context_t cx;
  logic [11:0] sh[9] = '{`ADDR_OSC_REFCLK, `ADDR_T1H_OD1, `ADDR_T1L_OD2, `ADDR_TIMER1_CTRL_OD3,
    `ADDR_T2_PAD, `ADDR_PR2_MEMCFG, `ADDR_ADC0_AN1, `ADDR_ADC1_AN0, `ADDR_PR4_VREF};
  logic [7:0] dflt[9];
  logic [7:0] alt[9];
  logic [7:0] slave_v;
  logic [7:0] mask_v;
  logic [7:0] d;

  shared_sfr_address_decode u_dut (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .req_i(req_i),
    .ctx_i(ctx_i),
    .rdata_o(rdata_o),
    .alias_select_o(alias_select_o),
    .soft_watchdog_en_o(soft_watchdog_en_o),
    .regulator_lowpower_en_o(regulator_lowpower_en_o),
    .serial_slave_addr_o(serial_slave_addr_o),
    .serial_addr_mask_o(serial_addr_mask_o),
    .parport_pair_o(parport_pair_o)
  );

  // 20 MHz clock
  initial
  begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // One access per call; back-to-back calls give back-to-back cycles
  task automatic acc(input logic [11:0] a, input logic w, input logic r,
                     input logic [7:0] dw, input logic [7:0] ex);
    @(posedge clock_i);
    req_i <= '{addr: a, wr: w, rd: r, wdata: dw};
    ctx_i <= cx;
    if (r)
      exp_q.push_back(ex);
  endtask

  // Bus idle for one cycle
  task automatic idle();
    @(posedge clock_i);
    req_i <= '0;
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    if (exp_q.size() != 0)
      err_total++;
    if (err_total == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Monitor: read data stands one cycle after the strobe
  always @(posedge clock_i)
    rd_d <= rst_n_i && req_i.rd;

  always @(negedge clock_i)
    if (rd_d)
    begin
      e = 8'hxx;
      if (exp_q.size() > 0)
        e = exp_q.pop_front();
      `CHK("rdata", e, rdata_o)
    end

  // Hang guard, well above the length of the sequence
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      wrap_up();
    end
  end

  // Main sequence
  initial
  begin
    void'($urandom(42435));
    rst_n_i = 1'b0;
    req_i = '0;
    cx = '{serial_ctrl2_low: 4'h0, parport_master: 1'b1, variant_80pin: 1'b1, core_supply_ok: 1'b1};
    ctx_i = cx;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(negedge clock_i);
    `CHK("alias_select", 1'b0, alias_select_o)
    `CHK("regulator_lowpower", 1'b0, regulator_lowpower_en_o)
    // Control byte: all ones written, unimplemented bits stay zero
    acc(`ADDR_WDT_CTRL, 1'b0, 1'b1, 8'h00, 8'h40);
    acc(`ADDR_WDT_CTRL, 1'b1, 1'b1, 8'hff, 8'h40);
    acc(`ADDR_WDT_CTRL, 1'b0, 1'b1, 8'h00, 8'hd1);
    cx.core_supply_ok = 1'b0;
    acc(`ADDR_WDT_CTRL, 1'b0, 1'b1, 8'h00, 8'h91);
    idle();
    @(negedge clock_i);
    `CHK("soft_watchdog", 1'b1, soft_watchdog_en_o)
    `CHK("regulator_lowpower", 1'b1, regulator_lowpower_en_o)
    // Shared slots: fill default side, then alternate side
    cx.core_supply_ok = 1'b1;
    acc(`ADDR_WDT_CTRL, 1'b1, 1'b0, 8'h00, 8'h00);
    foreach (sh[i])
    begin
      dflt[i] = 8'($urandom);
      acc(sh[i], 1'b1, 1'b1, dflt[i], 8'h00);
    end
    acc(`ADDR_WDT_CTRL, 1'b1, 1'b0, 8'h10, 8'h00);
    foreach (sh[i])
    begin
      alt[i] = 8'($urandom);
      acc(sh[i], 1'b1, 1'b1, alt[i], 8'h00);
    end
    foreach (sh[i])
      acc(sh[i], 1'b0, 1'b1, 8'h00, alt[i]);
    idle();
    @(negedge clock_i);
    `CHK("alias_select", 1'b1, alias_select_o)
    acc(`ADDR_WDT_CTRL, 1'b1, 1'b0, 8'h00, 8'h00);
    foreach (sh[i])
      acc(sh[i], 1'b0, 1'b1, 8'h00, dflt[i]);
    // Memory config alternate absent on the small package
    cx.variant_80pin = 1'b0;
    acc(`ADDR_PR2_MEMCFG, 1'b0, 1'b1, 8'h00, dflt[5]);
    acc(`ADDR_WDT_CTRL, 1'b1, 1'b0, 8'h10, 8'h00);
    acc(`ADDR_PR2_MEMCFG, 1'b1, 1'b1, 8'h5a, 8'h00);
    cx.variant_80pin = 1'b1;
    acc(`ADDR_PR2_MEMCFG, 1'b0, 1'b1, 8'h00, alt[5]);
    // Serial alias under every control nibble, select toggling
    slave_v = 8'h00;
    mask_v = 8'h00;
    for (int n = 0; n < 16; n++)
    begin
      cx.serial_ctrl2_low = 4'(n);
      d = 8'($urandom);
      acc(`ADDR_WDT_CTRL, 1'b1, 1'b0, n[0] ? 8'h10 : 8'h00, 8'h00);
      acc(`ADDR_SERIAL_ADDR, 1'b1, 1'b1, d, (n == 9) ? mask_v : slave_v);
      if (n == 9)
        mask_v = d;
      else
        slave_v = d;
      acc(`ADDR_SERIAL_ADDR, 1'b0, 1'b1, 8'h00, d);
    end
    idle();
    @(negedge clock_i);
    `CHK("serial_slave_addr", slave_v, serial_slave_addr_o)
    `CHK("serial_addr_mask", mask_v, serial_addr_mask_o)
    // Parallel pair written as address, read back as data-out
    acc(`ADDR_PARPORT_HIGH, 1'b1, 1'b0, 8'hc3, 8'h00);
    acc(`ADDR_PARPORT_LOW, 1'b1, 1'b0, 8'h3c, 8'h00);
    cx.parport_master = 1'b0;
    acc(`ADDR_PARPORT_HIGH, 1'b0, 1'b1, 8'h00, 8'hc3);
    acc(`ADDR_PARPORT_LOW, 1'b1, 1'b1, 8'h99, 8'h3c);
    // Unmapped address reads zero and keeps nothing
    acc(12'hfc9, 1'b1, 1'b1, 8'hff, 8'h00);
    idle();
    @(negedge clock_i);
    `CHK("parport_pair", 16'hc399, parport_pair_o)
    // Reset in mid-run clears the select
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    @(posedge clock_i);
    @(negedge clock_i);
    `CHK("alias_select", 1'b0, alias_select_o)
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    acc(`ADDR_WDT_CTRL, 1'b0, 1'b1, 8'h00, 8'h40);
    idle();
    repeat (3) @(posedge clock_i);
    wrap_up();
  end
endmodule
`default_nettype wire
